// *** core/tsr_core.sv ***
// trace speculation resolution: turns processing element reports
// into atom, resolution, event, overflow and transaction elements
// assumes op, levels and overflow pulse come from the sys_clk domain
// and that the element sink may stall with el_ready low
`timescale 1ns/1ps
`include "tsr_regs.svh"

module tsr_core
    import tsr_pkg::*;
#(
    parameter int unsigned SPEC_LIMIT = `TSR_SPEC_LIMIT
)
(
    input  wire logic                  sys_clk,
    input  wire logic                  rst_n,
    input  wire logic                  trace_en,
    input  wire logic                  pe_in_tx,
    input  wire logic                  wait_instruction_trace_mode,
    input  wire logic                  buf_ovf,
    input  wire logic                  op_valid,
    input  wire tsr_op_s               op_i,
    output logic                       op_ready,
    output logic                       el_valid,
    output tsr_elem_s                  el_o,
    input  wire logic                  el_ready,
    output logic [`TSR_ARG_W-1:0]      speculation_depth_limit,
    output logic [`TSR_ARG_W-1:0]      spec_count
);
    // ************************************************************
    // elaboration check
    // ************************************************************
    generate
        if (SPEC_LIMIT < 1 || SPEC_LIMIT > `TSR_SPEC_MAX) begin : g_bad
            $error("spec limit out of range");
        end
    endgenerate

    localparam logic [`TSR_ARG_W-1:0] LIM = `TSR_ARG_W'(SPEC_LIMIT);

    // ************************************************************
    // state
    // ************************************************************
    tsr_trc_e              trc_q;
    tsr_trc_e              trc_d;
    logic                  ovf_due_q;
    logic                  disc_due_q;
    logic                  tfail_due_q;
    logic                  ton_due_q;
    logic                  tst_due_q;
    logic                  tx_open_q;
    logic [`TSR_ARG_W-1:0] pc_q;
    logic [`TSR_ARG_W-1:0] pk_q;
    logic                  el_valid_q;
    tsr_elem_s             el_q;
    logic                  ovf_due_d;
    logic                  disc_due_d;
    logic                  tfail_due_d;
    logic                  ton_due_d;
    logic                  tst_due_d;
    logic                  tx_open_d;
    logic [`TSR_ARG_W-1:0] pc_d;
    logic [`TSR_ARG_W-1:0] pk_d;

    wire                   is_wp;
    wire                   spec_full;
    wire                   tx_gone;
    wire [`TSR_ARG_W-1:0]  spec_cnt;

    // ************************************************************
    // decode of the incoming op
    // ************************************************************
    tsr_classify u_cls (
        .cls                         (op_i.cls),
        .wait_instruction_trace_mode (wait_instruction_trace_mode),
        .is_direct                   (),
        .is_indirect                 (),
        .is_waypoint                 (is_wp)
    );

    wire trc_on    = (trc_q == TRC_ON);
    wire trc_rise  = (trc_q == TRC_OFF) & trace_en;
    wire trc_fall  = trc_on & ~trace_en;
    wire slot_free = ~el_valid_q | el_ready;
    wire acc_nz    = (pc_q != `TSR_CNT_RST) | (pk_q != `TSR_CNT_RST);
    wire work      = (spec_cnt != `TSR_CNT_RST) | acc_nz;
    wire is_instr  = (op_i.op == OP_INSTR);
    wire is_commit = (op_i.op == OP_COMMIT);
    wire is_cancel = (op_i.op == OP_CANCEL);
    wire is_txend  = (op_i.op == OP_TX_COMMIT) | (op_i.op == OP_TX_FAIL);
    wire wp_op     = is_instr & is_wp;
    wire tst_op    = wp_op & (op_i.cls == CLS_TSTART) & ~tx_open_q;

    wire [`TSR_ARG_W:0] csum = {1'b0, pc_q} + {1'b0, op_i.arg};
    // a commit joins the pending one only while the total stays below
    wire merge_cm  = is_commit & (pk_q == `TSR_CNT_RST) &
                     ((pc_q == `TSR_CNT_RST) | (csum < {1'b0, LIM}));
    // a cancel joins only when no commit count is pending
    wire merge_cn  = is_cancel & (pc_q == `TSR_CNT_RST);
    wire merge_ok  = op_valid & trc_on & (merge_cm | merge_cn);
    // pending counts leave in any cycle with a free element slot and no overflow due that brings no commit or cancel to merge into them
    wire flush_req = acc_nz & ~merge_ok;
    wire due_any   = ovf_due_q | disc_due_q | tfail_due_q | ton_due_q |
                     tst_due_q;

    wire op_emits  = wp_op | (op_i.op == OP_MISPRED) |
                     (op_i.op == OP_EVENT) | (is_txend & tx_open_q);
    // a new waypoint waits while the speculation window is full
    assign op_ready = ~trc_on |
                      (~due_any & ~flush_req & (~op_emits | slot_free) &
                       ~(wp_op & spec_full));
    wire op_acc    = op_valid & op_ready & trc_on;
    wire op_fire   = op_acc & op_emits;

    // ************************************************************
    // element selection, fixed priority
    // ************************************************************
    wire take_ovf   = slot_free & ovf_due_q;
    wire take_flush = slot_free & ~ovf_due_q & flush_req;
    wire pre_disc   = ovf_due_q | flush_req;
    wire take_disc  = slot_free & ~pre_disc & disc_due_q;
    wire pre_tfail  = pre_disc | disc_due_q;
    wire take_tfail = slot_free & ~pre_tfail & tfail_due_q;
    wire pre_ton    = pre_tfail | tfail_due_q;
    wire take_ton   = slot_free & ~pre_ton & ton_due_q;
    wire take_tst   = slot_free & ~pre_ton & ~ton_due_q & tst_due_q;
    wire ld_el      = take_ovf | take_flush | take_disc | take_tfail |
                      take_ton | take_tst | op_fire;
    wire flush_cm   = (pc_q != `TSR_CNT_RST);

    wire tsr_el_e op_kind =
        wp_op                      ? (op_i.taken ? EL_ATOM_E : EL_ATOM_N) :
        (op_i.op == OP_MISPRED)    ? EL_MISPRED :
        (op_i.op == OP_EVENT)      ? EL_EVENT :
        (op_i.op == OP_TX_COMMIT)  ? EL_TCOMMIT :
                                     EL_TFAIL;
    wire tsr_el_e ld_kind =
        take_ovf   ? EL_OVERFLOW :
        take_flush ? (flush_cm ? EL_COMMIT : EL_CANCEL) :
        take_disc  ? EL_DISCARD :
        take_tfail ? EL_TFAIL :
        take_ton   ? EL_TRACE_ON :
        take_tst   ? EL_TSTART :
                     op_kind;
    wire [`TSR_ARG_W-1:0] ld_pay =
        take_flush ? (flush_cm ? pc_q : pk_q) :
        (op_fire & (op_i.op == OP_EVENT)) ? op_i.arg :
                     `TSR_PAY_NONE;

    // ************************************************************
    // speculation window
    // ************************************************************
    wire        spec_push = op_fire & wp_op;
    wire        spec_clr  = trc_fall | take_ovf;
    wire [`TSR_ARG_W-1:0] cm_n = (op_acc & is_commit) ? op_i.arg :
                                 `TSR_CNT_RST;
    wire [`TSR_ARG_W-1:0] cn_n = (op_acc & is_cancel) ? op_i.arg :
                                 `TSR_CNT_RST;

    tsr_spec_track #(
        .LIMIT (SPEC_LIMIT)
    ) u_spec (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .push     (spec_push),
        .push_tx  (spec_push & tst_op),
        .clear    (spec_clr),
        .commit_n (cm_n),
        .cancel_n (cn_n),
        .cnt      (spec_cnt),
        .full     (spec_full),
        .tx_gone  (tx_gone)
    );

    // ************************************************************
    // next values
    // ************************************************************
    assign trc_d = trc_rise ? TRC_ON : trc_fall ? TRC_OFF : trc_q;

    // set wins over clear for the overflow flag
    assign ovf_due_d  = buf_ovf | (ovf_due_q & ~take_ovf);
    assign disc_due_d = ((trc_fall | take_ovf) & work) |
                        (disc_due_q & ~take_disc);
    // overflow inside a tx ends it so the analyzer drops that work
    assign tfail_due_d = (take_ovf & tx_open_q) |
                         (tfail_due_q & ~take_tfail & ~trc_fall);
    assign ton_due_d  = trc_rise | (ton_due_q & ~take_ton & ~trc_fall);

    wire tst_set = (take_ton | take_tfail) & pe_in_tx & trc_on &
                   ~trc_fall & ~tx_open_q;
    assign tst_due_d = tst_set | (op_fire & tst_op) |
                       (tst_due_q & ~take_tst & ~trc_fall);
    assign tx_open_d = tst_set | (op_fire & tst_op) |
                       (tx_open_q & ~take_ovf & ~tx_gone & ~trc_fall &
                        ~(op_acc & is_txend));

    assign pc_d = (spec_clr | (take_flush & flush_cm)) ? `TSR_CNT_RST :
                  (op_acc & is_commit) ? csum[`TSR_ARG_W-1:0] : pc_q;
    assign pk_d = (spec_clr | (take_flush & ~flush_cm)) ? `TSR_CNT_RST :
                  (op_acc & is_cancel) ? pk_q + op_i.arg : pk_q;

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            trc_q       <= TRC_OFF;
            ovf_due_q   <= 1'b0;
            disc_due_q  <= 1'b0;
            tfail_due_q <= 1'b0;
            ton_due_q   <= 1'b0;
            tst_due_q   <= 1'b0;
            tx_open_q   <= 1'b0;
            pc_q        <= `TSR_CNT_RST;
            pk_q        <= `TSR_CNT_RST;
        end else begin
            trc_q       <= trc_d;
            ovf_due_q   <= ovf_due_d;
            disc_due_q  <= disc_due_d;
            tfail_due_q <= tfail_due_d;
            ton_due_q   <= ton_due_d;
            tst_due_q   <= tst_due_d;
            tx_open_q   <= tx_open_d;
            pc_q        <= pc_d;
            pk_q        <= pk_d;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            el_valid_q <= 1'b0;
            el_q       <= '{kind: EL_ATOM_E, payload: `TSR_PAY_NONE};
        end else begin
            el_valid_q <= ld_el | (el_valid_q & ~el_ready);
            if (ld_el) begin
                el_q <= '{kind: ld_kind, payload: ld_pay};
            end
        end
    end

    assign el_valid                = el_valid_q;
    assign el_o                    = el_q;
    assign speculation_depth_limit = LIM;
    assign spec_count              = spec_cnt;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    spec_cap_a: assert property (spec_cnt <= LIM)
        else $error("speculation count above limit");
    wp_hold_a: assert property (
        trc_on && op_valid && wp_op && spec_full |-> !op_ready)
        else $error("waypoint taken with full window");
    merge_cap_a: assert property (
        op_acc && is_commit && pc_q != 8'h00 |=> pc_q < LIM)
        else $error("merged commit reached limit");
    atom_clean_a: assert property (
        ld_el && (ld_kind == EL_ATOM_E || ld_kind == EL_ATOM_N)
        |-> pk_q == 8'h00 && pc_q == 8'h00)
        else $error("atom emitted over pending resolution");
    commit_out_a: assert property (
        take_flush && flush_cm |=> el_valid_q && el_q.kind == EL_COMMIT
        && el_q.payload == $past(pc_q) && pc_q == 8'h00)
        else $error("commit element count wrong");
    cancel_out_a: assert property (
        take_flush && !flush_cm |=> el_valid_q && el_q.kind == EL_CANCEL
        && el_q.payload == $past(pk_q) && pk_q == 8'h00)
        else $error("cancel element count wrong");
    discard_due_a: assert property (
        trc_fall && spec_cnt != 8'h00 |=> disc_due_q && spec_cnt == 8'h00)
        else $error("discard not raised at trace stop");
    mispred_out_a: assert property (
        op_fire && op_i.op == OP_MISPRED |=> el_valid_q &&
        el_q.kind == EL_MISPRED)
        else $error("mispredict element missing");
    tstart_after_a: assert property (
        op_fire && tst_op |=> el_q.kind == EL_ATOM_E && tst_due_q
        && tx_open_q)
        else $error("tx start not queued after its waypoint");
    ton_tstart_a: assert property (
        take_ton && pe_in_tx && !tx_open_q && trace_en |=> tst_due_q
        ##0 el_q.kind == EL_TRACE_ON)
        else $error("tx start not queued after trace on");
    event_pay_a: assert property (
        op_fire && op_i.op == OP_EVENT |=> el_valid_q &&
        el_q.kind == EL_EVENT && el_q.payload == $past(op_i.arg))
        else $error("event element payload wrong");
    // a stalled element must not be overwritten or reordered
    el_hold_a: assert property (
        el_valid_q && !el_ready |=> el_valid_q && $stable(el_q))
        else $error("stalled element changed");
    ovf_seen_a: assert property (buf_ovf |=> ovf_due_q [*1])
        else $error("overflow lost");
    // overflow drops the whole window, nothing stays speculative
    ovf_out_a: assert property (
        take_ovf |=> el_valid_q && el_q.kind == EL_OVERFLOW
        && spec_cnt == 8'h00)
        else $error("overflow element or clear missing");
    tx_commit_a: assert property (
        op_fire && op_i.op == OP_TX_COMMIT |=> el_q.kind == EL_TCOMMIT
        && !tx_open_q)
        else $error("tx commit element missing");
    tfail_tstart_a: assert property (
        take_tfail && pe_in_tx && trace_en && !tx_open_q
        |=> el_q.kind == EL_TFAIL && tst_due_q)
        else $error("tx start not queued after tx failure");
    one_tstart_a: assert property (
        tx_open_q && !take_ovf && !tx_gone && !(op_acc && is_txend)
        && !trc_fall |=> !$rose(tst_due_q))
        else $error("second tx start in one transaction");

    merge_cv: cover property (op_acc && is_commit && pc_q != 8'h00);
    cancel_cv: cover property (take_flush && !flush_cm);
    ovf_tx_cv: cover property (take_ovf && tx_open_q ##[1:8] take_tst);
    discard_cv: cover property (take_disc);
    ton_tx_cv: cover property (take_ton && pe_in_tx ##1 take_tst);
endmodule

// *** core/tsr_regs.svh ***
// constants of the trace speculation resolution block
// assumes inclusion by bare name from the package and modules
`ifndef TSR_REGS_SVH
`define TSR_REGS_SVH

// ****************************************************************
// widths, limits and reset values
// ****************************************************************
`define TSR_ARG_W      8
`define TSR_SPEC_LIMIT 32
`define TSR_SPEC_MAX   255
`define TSR_CNT_RST    8'h00
`define TSR_PAY_NONE   8'h00

`endif

// *** core/tsr_pkg.sv ***
// types shared by the trace speculation resolution block
// assumes tsr_regs.svh is on the include path
package tsr_pkg;
    `include "tsr_regs.svh"

    // ************************************************************
    // instruction classes reported by the processing element
    // ************************************************************
    typedef enum logic [2:0] {
        CLS_OTHER,
        CLS_DBRANCH,
        CLS_IBRANCH,
        CLS_BARRIER,
        CLS_TSTART,
        CLS_WAIT
    } tsr_cls_e;

    typedef enum logic [2:0] {
        OP_INSTR,
        OP_COMMIT,
        OP_CANCEL,
        OP_MISPRED,
        OP_EVENT,
        OP_TX_COMMIT,
        OP_TX_FAIL
    } tsr_op_e;

    typedef enum logic [3:0] {
        EL_ATOM_E,
        EL_ATOM_N,
        EL_COMMIT,
        EL_CANCEL,
        EL_DISCARD,
        EL_MISPRED,
        EL_EVENT,
        EL_OVERFLOW,
        EL_TSTART,
        EL_TCOMMIT,
        EL_TFAIL,
        EL_TRACE_ON
    } tsr_el_e;

    typedef enum logic {
        TRC_OFF,
        TRC_ON
    } tsr_trc_e;

    // ************************************************************
    // carriers
    // ************************************************************
    typedef struct packed {
        tsr_op_e                 op;
        tsr_cls_e                cls;
        logic                    taken;
        logic [`TSR_ARG_W-1:0]   arg;
    } tsr_op_s;

    typedef struct packed {
        tsr_el_e                 kind;
        logic [`TSR_ARG_W-1:0]   payload;
    } tsr_elem_s;
endpackage

// *** core/tsr_classify.sv ***
// waypoint classifier for one reported instruction
// assumes the class code comes from the processing element decode
`timescale 1ns/1ps
module tsr_classify
    import tsr_pkg::*;
(
    input  wire tsr_cls_e cls,
    input  wire logic     wait_instruction_trace_mode,
    output logic          is_direct,
    output logic          is_indirect,
    output logic          is_waypoint
);
    // ************************************************************
    // direct and indirect waypoint decode
    // ************************************************************
    wire cls_wait = (cls == CLS_WAIT);

    assign is_direct   = (cls == CLS_DBRANCH) | (cls == CLS_BARRIER) |
                         (cls == CLS_TSTART) |
                         (cls_wait & wait_instruction_trace_mode);
    assign is_indirect = (cls == CLS_IBRANCH);
    assign is_waypoint = is_direct | is_indirect;
endmodule

// *** core/tsr_spec_track.sv ***
// count of unresolved waypoints and position of the open tx start
// assumes at most one of push, commit or cancel in a cycle
`timescale 1ns/1ps
`include "tsr_regs.svh"
module tsr_spec_track
    import tsr_pkg::*;
#(
    parameter int unsigned LIMIT = `TSR_SPEC_LIMIT
)
(
    input  wire logic                  sys_clk,
    input  wire logic                  rst_n,
    input  wire logic                  push,
    input  wire logic                  push_tx,
    input  wire logic                  clear,
    input  wire logic [`TSR_ARG_W-1:0] commit_n,
    input  wire logic [`TSR_ARG_W-1:0] cancel_n,
    output logic      [`TSR_ARG_W-1:0] cnt,
    output logic                       full,
    output logic                       tx_gone
);
    localparam logic [`TSR_ARG_W-1:0] LIM = `TSR_ARG_W'(LIMIT);

    logic [`TSR_ARG_W-1:0] cnt_q;
    logic [`TSR_ARG_W-1:0] cnt_d;
    logic [`TSR_ARG_W-1:0] txpos_q;
    logic [`TSR_ARG_W-1:0] txpos_d;
    wire  [`TSR_ARG_W-1:0] left = cnt_q - cancel_n;

    // ************************************************************
    // counting
    // ************************************************************
    // a cancel reaching the tx start waypoint also closes the open tx
    assign tx_gone = (txpos_q != `TSR_CNT_RST) && (cancel_n != 8'h00) &&
                     (txpos_q > left);
    assign cnt_d   = clear ? `TSR_CNT_RST :
                     cnt_q + {7'h00, push} - commit_n - cancel_n;
    assign txpos_d = clear | tx_gone     ? `TSR_CNT_RST :
                     push_tx             ? cnt_q + 8'h01 :
                     txpos_q > commit_n  ? txpos_q - commit_n :
                                           `TSR_CNT_RST;
    assign cnt     = cnt_q;
    assign full    = (cnt_q >= LIM);

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cnt_q   <= `TSR_CNT_RST;
            txpos_q <= `TSR_CNT_RST;
        end else begin
            cnt_q   <= cnt_d;
            txpos_q <= txpos_d;
        end
    end
endmodule

// *** dv/tsr_sink.sv ***
// trace element sink standing in for the analyzer
// assumes el_o and el_valid come from tsr_core on sys_clk
`timescale 1ns/1ps
module tsr_sink
    import tsr_pkg::*;
(
    input  wire logic      sys_clk,
    input  wire logic      rst_n,
    input  wire logic      slow,
    input  wire logic      el_valid,
    input  wire tsr_elem_s el_o,
    output logic           el_ready
);
    tsr_elem_s  got[$];
    int         open_cnt;
    logic [1:0] ph;

    initial begin
        el_ready = 1'b1;
        ph = 2'h0;
        open_cnt = 0;
    end
    // stall two of three cycles when slow, so elements must hold
    always @(negedge sys_clk) begin
        ph = (ph == 2'h2) ? 2'h0 : ph + 2'h1;
        el_ready = !slow || (ph == 2'h0);
    end
    always @(posedge sys_clk) begin
        if (rst_n && el_valid && el_ready) begin
            got.push_back(el_o);
            case (el_o.kind)
                EL_ATOM_E, EL_ATOM_N: open_cnt = open_cnt + 1;
                EL_COMMIT, EL_CANCEL: open_cnt = open_cnt - el_o.payload;
                EL_DISCARD: open_cnt = 0;
                EL_TFAIL: open_cnt = 0;
                default: ;
            endcase
        end
    end
endmodule

// *** dv/tsr_core_test.sv ***
// self-checking bench for tsr_core with the sink model
// assumes tsr_pkg is compiled first
`timescale 1ns/1ps
module tsr_core_test;
    import tsr_pkg::*;
    localparam int unsigned LIM = 4;
    logic       sys_clk = 1'b0;
    logic       rst_n = 1'b0;
    logic       trace_en = 1'b0;
    logic       pe_in_tx = 1'b0;
    logic       wmode = 1'b0;
    logic       buf_ovf = 1'b0;
    logic       op_valid = 1'b0;
    tsr_op_s    op_i = '0;
    logic       op_ready;
    logic       el_valid;
    tsr_elem_s  el_o;
    logic       el_ready;
    logic       slow = 1'b0;
    logic [7:0] lim_o;
    logic [7:0] spec_count;
    int         miscompares = 0;
    int         cmp_count = 0;

    always #50 sys_clk = ~sys_clk;

    tsr_core #(.SPEC_LIMIT(LIM)) u_dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .trace_en(trace_en),
        .pe_in_tx(pe_in_tx), .wait_instruction_trace_mode(wmode),
        .buf_ovf(buf_ovf), .op_valid(op_valid), .op_i(op_i),
        .op_ready(op_ready), .el_valid(el_valid), .el_o(el_o),
        .el_ready(el_ready), .speculation_depth_limit(lim_o),
        .spec_count(spec_count));
    tsr_sink u_sink (.sys_clk(sys_clk), .rst_n(rst_n), .slow(slow),
        .el_valid(el_valid), .el_o(el_o), .el_ready(el_ready));

    // ************************************************************
    // shared tasks
    // ************************************************************
    task automatic print_verdict();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic hang();
        miscompares++;
        $display("[ERR] t=%0t got %h exp %h", $time, 8'hff, 8'h00);
        print_verdict();
    endtask
    // op_valid stays up after return so ops can go back to back
    task automatic send(input tsr_op_e op, input tsr_cls_e cls,
                        input logic tk, input logic [7:0] arg);
        int n;
        n = 0;
        @(negedge sys_clk);
        op_valid = 1'b1;
        op_i = '{op, cls, tk, arg};
        #1;
        while (op_ready !== 1'b1 && n < 60) begin
            @(negedge sys_clk);
            #1;
            n++;
        end
        if (op_ready !== 1'b1) hang();
        @(posedge sys_clk);
    endtask
    task automatic wp(input tsr_cls_e cls, input logic tk);
        send(OP_INSTR, cls, tk, 8'h00);
    endtask
    task automatic idle();
        @(negedge sys_clk);
        op_valid = 1'b0;
    endtask
    task automatic exp_el(input tsr_el_e k, input logic [7:0] p);
        int        n;
        tsr_elem_s e;
        n = 0;
        while (u_sink.got.size() == 0 && n < 60) begin
            @(negedge sys_clk);
            n++;
        end
        if (u_sink.got.size() == 0) hang();
        e = u_sink.got.pop_front();
        cmp_count++;
        if (e.kind !== k || e.payload !== p) begin
            miscompares++;
            $display("[ERR] t=%0t got %h exp %h", $time, e, {k, p});
        end
    endtask
    task automatic cmp_val(input logic [7:0] g, input logic [7:0] x);
        cmp_count++;
        if (g !== x) begin
            miscompares++;
            $display("[ERR] t=%0t got %h exp %h", $time, g, x);
        end
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_commit();
        wp(CLS_DBRANCH, 1'b1);
        idle();
        wmode = 1'b0;
        wp(CLS_WAIT, 1'b1);
        wp(CLS_IBRANCH, 1'b1);
        idle();
        wmode = 1'b1;
        wp(CLS_WAIT, 1'b1);
        send(OP_COMMIT, CLS_OTHER, 1'b0, 8'h01);
        send(OP_COMMIT, CLS_OTHER, 1'b0, 8'h02);
        idle();
        repeat (3) exp_el(EL_ATOM_E, 8'h00);
        exp_el(EL_COMMIT, 8'h03);
        cmp_val(spec_count, 8'h00);
        cmp_val(u_sink.open_cnt[7:0], 8'h00);
    endtask
    task automatic t_cancel();
        wp(CLS_DBRANCH, 1'b0);
        wp(CLS_BARRIER, 1'b1);
        send(OP_CANCEL, CLS_OTHER, 1'b0, 8'h01);
        send(OP_CANCEL, CLS_OTHER, 1'b0, 8'h01);
        send(OP_MISPRED, CLS_OTHER, 1'b0, 8'h00);
        send(OP_EVENT, CLS_OTHER, 1'b0, 8'h05);
        send(OP_EVENT, CLS_OTHER, 1'b0, 8'h09);
        idle();
        exp_el(EL_ATOM_N, 8'h00);
        exp_el(EL_ATOM_E, 8'h00);
        exp_el(EL_CANCEL, 8'h02);
        exp_el(EL_MISPRED, 8'h00);
        exp_el(EL_EVENT, 8'h05);
        exp_el(EL_EVENT, 8'h09);
    endtask
    task automatic t_tx();
        pe_in_tx = 1'b1;
        wp(CLS_TSTART, 1'b1);
        idle();
        exp_el(EL_ATOM_E, 8'h00);
        exp_el(EL_TSTART, 8'h00);
        pe_in_tx = 1'b0;
        send(OP_TX_COMMIT, CLS_OTHER, 1'b0, 8'h00);
        idle();
        exp_el(EL_TCOMMIT, 8'h00);
        cmp_val(spec_count, 8'h01);
    endtask
    task automatic t_ovf();
        @(negedge sys_clk);
        buf_ovf = 1'b1;
        @(negedge sys_clk);
        buf_ovf = 1'b0;
        exp_el(EL_OVERFLOW, 8'h00);
        exp_el(EL_DISCARD, 8'h00);
        cmp_val(spec_count, 8'h00);
    endtask
    // overflow inside a tx: failure, then a fresh start while still in tx
    task automatic t_ovf_tx();
        pe_in_tx = 1'b1;
        wp(CLS_TSTART, 1'b1);
        idle();
        exp_el(EL_ATOM_E, 8'h00);
        exp_el(EL_TSTART, 8'h00);
        @(negedge sys_clk);
        buf_ovf = 1'b1;
        @(negedge sys_clk);
        buf_ovf = 1'b0;
        exp_el(EL_OVERFLOW, 8'h00);
        exp_el(EL_DISCARD, 8'h00);
        exp_el(EL_TFAIL, 8'h00);
        exp_el(EL_TSTART, 8'h00);
        pe_in_tx = 1'b0;
        send(OP_TX_FAIL, CLS_OTHER, 1'b0, 8'h00);
        idle();
        exp_el(EL_TFAIL, 8'h00);
        cmp_val(u_sink.open_cnt[7:0], 8'h00);
    endtask
    task automatic t_limit();
        slow = 1'b1;
        cmp_val(lim_o, LIM[7:0]);
        repeat (LIM) wp(CLS_DBRANCH, 1'b1);
        repeat (LIM) exp_el(EL_ATOM_E, 8'h00);
        @(negedge sys_clk);
        op_i = '{OP_INSTR, CLS_IBRANCH, 1'b1, 8'h00};
        // one op past the depth limit must be held off
        repeat (5) begin
            @(negedge sys_clk);
            #1;
            cmp_val({7'h00, op_ready}, 8'h00);
        end
        // sum equal to the limit must not merge
        send(OP_COMMIT, CLS_OTHER, 1'b0, 8'h02);
        send(OP_COMMIT, CLS_OTHER, 1'b0, 8'h02);
        idle();
        exp_el(EL_COMMIT, 8'h02);
        exp_el(EL_COMMIT, 8'h02);
        slow = 1'b0;
    endtask
    task automatic t_off();
        wp(CLS_DBRANCH, 1'b1);
        idle();
        exp_el(EL_ATOM_E, 8'h00);
        @(negedge sys_clk);
        trace_en = 1'b0;
        exp_el(EL_DISCARD, 8'h00);
        cmp_val(spec_count, 8'h00);
        @(negedge sys_clk);
        pe_in_tx = 1'b1;
        trace_en = 1'b1;
        exp_el(EL_TRACE_ON, 8'h00);
        exp_el(EL_TSTART, 8'h00);
        pe_in_tx = 1'b0;
    endtask

    initial begin
        repeat (3) @(negedge sys_clk);
        rst_n = 1'b1;
        cmp_val(spec_count, 8'h00);
        trace_en = 1'b1;
        exp_el(EL_TRACE_ON, 8'h00);
        t_commit();
        t_cancel();
        t_tx();
        t_ovf();
        t_ovf_tx();
        t_limit();
        t_off();
        print_verdict();
    end
endmodule
